// [logic/dpw_cfg.svh]
/*
  Constants of the dual PWM output unit: timing, register offsets,
  field positions and reset values. Assumes a 125 MHz aclk.
*/
// Behaviour
// - Two PWM outputs, each with its own duty and period settings.
// - Duty and period are each a 16-bit unsigned word.
// - Duty maps linearly; 0x0000 always low, 0xFFFF always high.
// - Period word is the cycle length in microseconds.
// - Period words 0 to 10 clamp to 10 us, at most 100 kHz.
// - Each LED shows the same waveform as its output.
// - Link setting none: output 2 runs from its own words only.
// - Mirror mode: output 2 copies output 1 edge for edge.
// - Inverted mirror mode: output 2 is the complement of output 1.
`ifndef DPW_CFG_SVH
`define DPW_CFG_SVH

`define DPW_CLK_PERIOD_NS 8
`define DPW_US_NS         1000
`define DPW_US_CYC        (`DPW_US_NS / `DPW_CLK_PERIOD_NS)
`define DPW_MIN_PERIOD_US 16'h000A
`define DPW_DUTY_ZERO     16'h0000
`define DPW_DUTY_FULL     16'hFFFF

`define DPW_REG_CTRL      8'h00
`define DPW_REG_DUTY1     8'h04
`define DPW_REG_PER1      8'h08
`define DPW_REG_DUTY2     8'h0C
`define DPW_REG_PER2      8'h10
`define DPW_REG_STATUS    8'h14

`define DPW_CTRL_EN1      0
`define DPW_CTRL_EN2      1
`define DPW_CTRL_LINK_LSB 2
`define DPW_CTRL_LINK_MSB 3

`define DPW_CTRL_RST      4'h0
`define DPW_DUTY_RST      16'h0000
`define DPW_PER_RST       16'h0000

`define DPW_RESP_OKAY     2'h0
`define DPW_RESP_SLVERR   2'h2

`endif

// [logic/dpw_pkg.sv]
/*
  Types of the dual PWM output unit.
  Assumes the constants of dpw_cfg.svh alongside.
*/
package dpw_pkg;
  typedef logic [15:0] dpw_word_t;
  typedef logic [22:0] dpw_cyc_t;
  typedef enum logic [1:0] {
    DPW_LINK_NONE,
    DPW_MIRROR_MODE,
    DPW_INVERTED_MIRROR_MODE,
    DPW_LINK_RSVD
  } dpw_link_t;
endpackage

// [logic/dpw_chan_if.sv]
/*
  Carrier between the register top and one PWM channel.
  Assumes both ends share aclk.
*/
`timescale 1ns/100ps
interface dpw_chan_if;
  import dpw_pkg::*;
  logic      en;
  dpw_word_t duty;
  dpw_word_t period;
  logic      pwm;
  logic      wrap;
  logic      running;
  modport ctl  (output en, duty, period, input pwm, wrap, running);
  modport chan (input en, duty, period, output pwm, wrap, running);
endinterface

// [logic/dpw_channel.sv]
/*
  One PWM channel: free-running cycle counter, clamped period, duty compare.
  Assumes words come from registers on the same aclk.
*/
`timescale 1ns/100ps
`include "dpw_cfg.svh"
module dpw_channel (
  input wire logic aclk,
  input wire logic aresetn,
  dpw_chan_if.chan ch
);
  import dpw_pkg::*;

  localparam dpw_cyc_t MIN_CYC = dpw_cyc_t'(`DPW_MIN_PERIOD_US * `DPW_US_CYC);

  dpw_word_t   per_us_w;
  dpw_cyc_t    per_cyc_w;
  logic [38:0] prod_w;
  dpw_cyc_t    hi_cyc_w;
  logic        wrap_w;
  logic        load_w;
  logic        run_q;
  dpw_cyc_t    cnt_q;
  dpw_cyc_t    per_q;
  dpw_cyc_t    hi_q;
  logic        pwm_q;

  assign per_us_w  = (ch.period < `DPW_MIN_PERIOD_US) ? `DPW_MIN_PERIOD_US : ch.period;
  assign per_cyc_w = dpw_cyc_t'(per_us_w * `DPW_US_CYC);
  assign prod_w    = per_cyc_w * ch.duty;
  // Top 23 bits approximate /65535; full scale forced so 0xFFFF never dips
  assign hi_cyc_w  = (ch.duty == `DPW_DUTY_FULL) ? per_cyc_w : prod_w[38:16];
  assign wrap_w    = run_q && (cnt_q == per_q - 23'd1);
  assign load_w    = !run_q || wrap_w;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= 1'b0;
      cnt_q <= '0;
      per_q <= '0;
      hi_q  <= '0;
      pwm_q <= 1'b0;
    end else begin
      run_q <= ch.en;
      cnt_q <= (load_w || !ch.en) ? '0 : cnt_q + 23'd1;
      if (load_w) begin
        per_q <= per_cyc_w;
        hi_q  <= hi_cyc_w;
      end
      pwm_q <= run_q && (cnt_q < hi_q);
    end
  end

  assign ch.pwm     = pwm_q;
  assign ch.wrap    = wrap_w;
  assign ch.running = run_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_count_bound: assert property (run_q |-> cnt_q < per_q)
    else $error("counter ran past period");
  a_hold_midperiod: assert property ((run_q && !wrap_w) |=> $stable(per_q) && $stable(hi_q))
    else $error("settings changed inside a period");
  // Enable must still stand after the wrap, else a stop right there would trip it
  a_wrap_restart: assert property ((wrap_w && ch.en) ##1 ch.en
                                   |-> cnt_q == 23'd0 ##1 cnt_q == 23'd1)
    else $error("counter did not restart at wrap");
  a_min_period: assert property (run_q |-> per_q >= MIN_CYC)
    else $error("period below 10 us");
  a_period_scale: assert property ((!run_q && ch.period == 16'h0064) |=> per_q == 23'd12500)
    else $error("100 us period not 12500 cycles");
  a_zero_low: assert property ((run_q && hi_q == 23'd0) |=> !pwm_q)
    else $error("zero duty drove high");
  a_full_high: assert property ((run_q && hi_q == per_q) |=> pwm_q)
    else $error("full duty drove low");
  c_wrap: cover property (wrap_w ##1 pwm_q);
endmodule

// [logic/dpw_top.sv]
/*
  Dual PWM output unit: AXI4-Lite register slave, two channels,
  channel link select and LED drive.
  Assumes a single 125 MHz aclk and a well-behaved AXI4-Lite master.
*/
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "dpw_cfg.svh"
module dpw_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output wire logic        pwm_out1,
  output wire logic        pwm_out2,
  output wire logic        led1,
  output wire logic        led2
);
  import dpw_pkg::*;

  dpw_chan_if c1 ();
  dpw_chan_if c2 ();

  logic [3:0]  ctrl_q;
  dpw_word_t   duty1_q;
  dpw_word_t   per1_q;
  dpw_word_t   duty2_q;
  dpw_word_t   per2_q;
  logic        aw_have_q;
  logic [7:0]  awaddr_q;
  logic        w_have_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        out1_q;
  logic        out2_q;
  logic        led1_q;
  logic        led2_q;

  logic        aw_fire_w;
  logic        w_fire_w;
  logic        ar_fire_w;
  logic        do_wr_w;
  dpw_word_t   wmask_w;
  dpw_word_t   wword_w;
  logic        wr_map_w;
  logic        rd_map_w;
  logic [31:0] rd_data_w;
  logic [3:0]  status_w;
  dpw_link_t   link_w;
  logic        out2_sel_w;

  function automatic dpw_word_t merge(dpw_word_t old, dpw_word_t nw, dpw_word_t m);
    return (old & ~m) | (nw & m);
  endfunction

  // Address and data may arrive in either order; both are parked first
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign aw_fire_w     = s_axi_awvalid && s_axi_awready;
  assign w_fire_w      = s_axi_wvalid && s_axi_wready;
  assign ar_fire_w     = s_axi_arvalid && s_axi_arready;
  assign do_wr_w       = aw_have_q && w_have_q;
  assign wmask_w       = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wword_w       = wdata_q[15:0];

  assign wr_map_w = (awaddr_q == `DPW_REG_CTRL)  || (awaddr_q == `DPW_REG_DUTY1) ||
                    (awaddr_q == `DPW_REG_PER1)  || (awaddr_q == `DPW_REG_DUTY2) ||
                    (awaddr_q == `DPW_REG_PER2)  || (awaddr_q == `DPW_REG_STATUS);
  assign rd_map_w = (s_axi_araddr == `DPW_REG_CTRL)  || (s_axi_araddr == `DPW_REG_DUTY1) ||
                    (s_axi_araddr == `DPW_REG_PER1)  || (s_axi_araddr == `DPW_REG_DUTY2) ||
                    (s_axi_araddr == `DPW_REG_PER2)  || (s_axi_araddr == `DPW_REG_STATUS);

  assign status_w  = {c2.running, c1.running, out2_q, out1_q};
  assign rd_data_w = (s_axi_araddr == `DPW_REG_CTRL)   ? {28'h0000000, ctrl_q} :
                     (s_axi_araddr == `DPW_REG_DUTY1)  ? {16'h0000, duty1_q} :
                     (s_axi_araddr == `DPW_REG_PER1)   ? {16'h0000, per1_q} :
                     (s_axi_araddr == `DPW_REG_DUTY2)  ? {16'h0000, duty2_q} :
                     (s_axi_araddr == `DPW_REG_PER2)   ? {16'h0000, per2_q} :
                     (s_axi_araddr == `DPW_REG_STATUS) ? {28'h0000000, status_w} :
                     32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= 8'h00;
      w_have_q  <= 1'b0;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `DPW_RESP_OKAY;
    end else begin
      if (aw_fire_w) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (do_wr_w) begin
        aw_have_q <= 1'b0;
      end
      if (w_fire_w) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (do_wr_w) begin
        w_have_q <= 1'b0;
      end
      if (do_wr_w) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_map_w ? `DPW_RESP_OKAY : `DPW_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q  <= `DPW_CTRL_RST;
      duty1_q <= `DPW_DUTY_RST;
      per1_q  <= `DPW_PER_RST;
      duty2_q <= `DPW_DUTY_RST;
      per2_q  <= `DPW_PER_RST;
    end else if (do_wr_w) begin
      if (awaddr_q == `DPW_REG_CTRL && wstrb_q[0]) ctrl_q <= wdata_q[3:0];
      if (awaddr_q == `DPW_REG_DUTY1) duty1_q <= merge(duty1_q, wword_w, wmask_w);
      if (awaddr_q == `DPW_REG_PER1)  per1_q  <= merge(per1_q, wword_w, wmask_w);
      if (awaddr_q == `DPW_REG_DUTY2) duty2_q <= merge(duty2_q, wword_w, wmask_w);
      if (awaddr_q == `DPW_REG_PER2)  per2_q  <= merge(per2_q, wword_w, wmask_w);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `DPW_RESP_OKAY;
    end else if (ar_fire_w) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_data_w;
      rresp_q  <= rd_map_w ? `DPW_RESP_OKAY : `DPW_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  assign c1.en     = ctrl_q[`DPW_CTRL_EN1];
  assign c1.duty   = duty1_q;
  assign c1.period = per1_q;
  assign c2.en     = ctrl_q[`DPW_CTRL_EN2];
  assign c2.duty   = duty2_q;
  assign c2.period = per2_q;

  dpw_channel u_ch1 (.aclk(aclk), .aresetn(aresetn), .ch(c1.chan));
  dpw_channel u_ch2 (.aclk(aclk), .aresetn(aresetn), .ch(c2.chan));

  // Reserved link code behaves as none
  assign link_w     = dpw_link_t'(ctrl_q[`DPW_CTRL_LINK_MSB:`DPW_CTRL_LINK_LSB]);
  assign out2_sel_w = (link_w == DPW_MIRROR_MODE)          ? c1.pwm :
                      (link_w == DPW_INVERTED_MIRROR_MODE) ? !c1.pwm :
                      c2.pwm;

  // Both outputs retimed in one stage so mirrored edges land on the same clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out1_q <= 1'b0;
      out2_q <= 1'b0;
      led1_q <= 1'b0;
      led2_q <= 1'b0;
    end else begin
      out1_q <= c1.pwm;
      out2_q <= out2_sel_w;
      led1_q <= c1.pwm;
      led2_q <= out2_sel_w;
    end
  end

  assign pwm_out1 = out1_q;
  assign pwm_out2 = out2_q;
  assign led1     = led1_q;
  assign led2     = led2_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_disabled_low: assert property (!ctrl_q[`DPW_CTRL_EN1] [*3] |=> !pwm_out1)
    else $error("disabled channel 1 drove high");
  a_duty_write: assert property ((do_wr_w && awaddr_q == `DPW_REG_DUTY1 && wstrb_q[1:0] == 2'b11)
                                 |=> duty1_q == $past(wdata_q[15:0]))
    else $error("duty word not stored");
  a_led_track: assert property (led1 == pwm_out1 && led2 == pwm_out2)
    else $error("LED differs from output");
  a_link_none: assert property ((link_w == DPW_LINK_NONE) |=> pwm_out2 == $past(c2.pwm))
    else $error("output 2 not from own channel");
  a_mirror_follow: assert property ((link_w == DPW_MIRROR_MODE) |=> pwm_out2 == pwm_out1)
    else $error("mirror output differs");
  a_invert_follow: assert property ((link_w == DPW_INVERTED_MIRROR_MODE)
                                    |=> pwm_out2 == !pwm_out1)
    else $error("inverted output not complement");
  a_bresp_hold: assert property ((bvalid_q && !s_axi_bready) |=> bvalid_q && $stable(bresp_q))
    else $error("write response dropped");
  a_read_answer: assert property (ar_fire_w |=> rvalid_q)
    else $error("read not answered next cycle");

  c_mirror: cover property (link_w == DPW_MIRROR_MODE && $rose(pwm_out1));
  c_invert: cover property (link_w == DPW_INVERTED_MIRROR_MODE && $rose(pwm_out1));
  c_write: cover property (bvalid_q && s_axi_bready);
  c_read: cover property (rvalid_q && s_axi_rready);
endmodule

// [testbench/dpw_top_bench.sv]
/*
  Self-checking bench of the dual PWM output unit: register access,
  waveform timing, LED copies and the channel link settings.
  Assumes dpw_top, dpw_pkg and dpw_cfg.svh compiled alongside.
*/
`timescale 1ns/100ps
`include "dpw_cfg.svh"
module dpw_top_bench;
  import dpw_pkg::*;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic   pwm_out1, pwm_out2, led1, led2;
  int          fail_count = 0, checks_done = 0;
  logic [15:0] seed_q = 16'h000F;
  logic [15:0] pw [4] = '{16'h0000, 16'h000A, 16'h000B, 16'h0014};
  logic [31:0] v, r, h, p, d;
  logic [1:0]  resp;

  always #4 aclk = ~aclk;

  dpw_top i_dpw_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_out1, .pwm_out2, .led1, .led2);

  function logic [15:0] rnd();
    seed_q = {seed_q[14:0], seed_q[15] ^ seed_q[13] ^ seed_q[12] ^ seed_q[10]};
    return seed_q;
  endfunction

  function logic [31:0] per_cyc(logic [15:0] w);
    return ((w < 16'h000A) ? 32'h0000000A : 32'(w)) * 32'h0000007D;
  endfunction

  function logic [31:0] exp_hi(logic [15:0] w, logic [15:0] dt);
    return (dt == 16'hFFFF) ? per_cyc(w) : (per_cyc(w) * 32'(dt)) >> 16;
  endfunction

  function logic cur(bit ch);
    return ch ? pwm_out2 : pwm_out1;
  endfunction

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task tally_and_finish();
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Handshakes sampled at the falling edge, acted on at the next rising edge
  // Waits as long as the answer takes; only the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] dw, output logic [1:0] br);
    bit ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= dw;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    tb = 0;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dr, output logic [1:0] rr);
    bit ta, tr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    tr = 0;
    while (!tr) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      dr = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask

  // One full cycle from a rising edge: high count and length
  task automatic meas(input bit ch, output logic [31:0] hi, output logic [31:0] pl);
    logic c, q;
    int n;
    q = 1'h1;
    n = 0;
    do begin
      @(negedge aclk);
      c = cur(ch);
      n++;
      if (c === 1'h1 && q === 1'h0) break;
      q = c;
    end while (n < 6000);
    hi = 0;
    pl = 0;
    do begin
      if (c === 1'h1) hi++;
      pl++;
      @(negedge aclk);
      q = c;
      c = cur(ch);
    end while (!(c === 1'h1 && q === 1'h0) && pl < 9000);
  endtask

  task automatic hold_check(input bit ch, input logic inv, input int skip);
    int bad;
    bad = 0;
    repeat (skip) @(posedge aclk);
    repeat (1400) begin
      @(negedge aclk);
      if (cur(ch) !== (inv ^ (ch ? pwm_out1 : 1'h0))) bad++;
    end
    chk(bad, 0);
  endtask

  always @(negedge aclk) begin
    if (aresetn) chk({led2, led1}, {pwm_out2, pwm_out1});
  end

  initial begin
    // Planned tests need about 40000 cycles
    #(8 * 90000);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i), r, resp);
      chk(r, 32'h00000000);
      chk(32'(resp), 32'(`DPW_RESP_OKAY));
    end
    rd(8'h18, r, resp);
    chk(r, 32'h00000000);
    chk(32'(resp), 32'(`DPW_RESP_SLVERR));
    wr(8'h20, 32'hFFFFFFFF, resp);
    chk(resp, `DPW_RESP_SLVERR);
    wr(`DPW_REG_STATUS, 32'h0000000F, resp);
    rd(`DPW_REG_STATUS, r, resp);
    chk(r, 32'h0);
    for (int i = 1; i < 5; i++) begin
      v = {rnd(), rnd()};
      wr(8'(4 * i), v, resp);
      rd(8'(4 * i), r, resp);
      chk(r, v & 32'h0000FFFF);
    end
    // Channel 2 parked at 100 us while stopped, so the period scaling is exercised
    wr(`DPW_REG_PER2, 32'h00000064, resp);
    for (int i = 0; i < 4; i++) begin
      // Full scale kept out: a constant high output has no edge to measure
      d = (i == 0) ? 32'h7FFF : (i == 1) ? 32'h3FFF : 32'((rnd() | 16'h1000) & 16'hFFFE);
      wr(`DPW_REG_PER1, 32'(pw[i]), resp);
      wr(`DPW_REG_DUTY1, d, resp);
      wr(`DPW_REG_CTRL, 32'h1, resp);
      meas(0, h, p);
      meas(0, h, p);
      chk(p, per_cyc(pw[i]));
      chk(h, exp_hi(pw[i], d[15:0]));
    end
    wr(`DPW_REG_DUTY1, 32'(`DPW_DUTY_ZERO), resp);
    hold_check(0, 1'h0, 2700);
    wr(`DPW_REG_DUTY1, 32'(`DPW_DUTY_FULL), resp);
    hold_check(0, 1'h1, 2700);
    wr(`DPW_REG_PER1, 32'h000A, resp);
    wr(`DPW_REG_DUTY1, 32'h3FFF, resp);
    wr(`DPW_REG_DUTY2, 32'h7FFF, resp);
    wr(`DPW_REG_PER2, 32'h000B, resp);
    wr(`DPW_REG_CTRL, 32'h3 | (32'(DPW_LINK_NONE) << `DPW_CTRL_LINK_LSB), resp);
    meas(1, h, p);
    meas(1, h, p);
    chk(h, exp_hi(16'h000B, 16'h7FFF));
    chk(p, per_cyc(16'h000B));
    wr(`DPW_REG_CTRL, 32'h3 | (32'(DPW_MIRROR_MODE) << `DPW_CTRL_LINK_LSB), resp);
    hold_check(1, 1'h0, 5);
    wr(`DPW_REG_CTRL, 32'h3 | (32'(DPW_INVERTED_MIRROR_MODE) << `DPW_CTRL_LINK_LSB), resp);
    hold_check(1, 1'h1, 5);
    tally_and_finish();
  end
endmodule
